// >>> hw/pcc_map.svh
// Offsets, field positions, reset values and timing counts of the card interface
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// ==========================================
// CPU-side register offsets
`define PCC_REG_CTRL      4'h0
`define PCC_REG_STATUS    4'h1
`define PCC_REG_MASK      4'h2
`define PCC_REG_IO_BASE   4'h3
`define PCC_REG_IO_MASK   4'h4
`define PCC_REG_MBX       4'h5
`define PCC_REG_COR       4'h6
`define PCC_REG_ATTR_ADDR 4'h7
`define PCC_REG_ATTR_DATA 4'h8

// ==========================================
// CPU control register fields
`define PCC_CTRL_READY    0
`define PCC_CTRL_STATUS_CHANGE_OUT   1
`define PCC_CTRL_IO_ALL   2
`define PCC_CTRL_RST      8'h00

// ==========================================
// Event bits, shared by status and mask
`define PCC_EV_CARD_RST   0
`define PCC_EV_HOST_WR    1
`define PCC_EV_HOST_RD    2
`define PCC_EV_CFG_WR     3
`define PCC_EV_W          4

// ==========================================
// Host configuration registers, host_addr[9:1]
`define PCC_CFG_COR       9'h100
`define PCC_CFG_CSR       9'h101
`define PCC_COR_LEVEL     6
`define PCC_COR_RST       8'h00
`define PCC_CSR_INTR      1

// ==========================================
// Timing
`define PCC_CLK_NS        50
`define PCC_IRQ_PULSE_NS  1000
`define PCC_IRQ_PULSE_CYC \
  ((`PCC_IRQ_PULSE_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)

`endif

// >>> hw/pcc_pkg.sv
// Types of the card host interface
package pcc_pkg;

  // Host socket pins, all inputs
  typedef struct packed {
    logic       oe_n;
    logic       ce_n;
    logic       reg_n;
    logic       we_n;
    logic       iord_n;
    logic       iowr_n;
    logic [9:0] addr;
    logic [7:0] data;
  } pcc_host_in_t;

  // Host data bus driven by the card
  typedef struct packed {
    logic [7:0] data;
    logic       oe;
  } pcc_host_out_t;

  typedef enum logic [1:0] {
    IRQ_IDLE  = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_HOLD  = 2'b11
  } pcc_irq_st_t;

endpackage

// >>> hw/pcc_attr_ram.sv
// Attribute memory, two ports with registered read data
`timescale 1ns/1ps
`default_nettype none

module pcc_attr_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          a_we_i,
  input  wire logic [AW-1:0] a_addr_i,
  input  wire logic [DW-1:0] a_wdata_i,
  output var  logic [DW-1:0] a_rdata_o,
  input  wire logic          b_we_i,
  input  wire logic [AW-1:0] b_addr_i,
  input  wire logic [DW-1:0] b_wdata_i,
  output var  logic [DW-1:0] b_rdata_o
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // Host port wins a same-address collision
  always_ff @(posedge clk_i) begin
    if (b_we_i) begin
      mem_q[b_addr_i] <= b_wdata_i;
    end
    if (a_we_i) begin
      mem_q[a_addr_i] <= a_wdata_i;
    end
    a_rdata_o <= mem_q[a_addr_i];
    b_rdata_o <= mem_q[b_addr_i];
  end

endmodule

`default_nettype wire

// >>> hw/pcc_host_if.sv
// Card-side host socket interface with mailbox and attribute memory
// How it works
// - OE, card enable and register select all low read attribute or config.
// - Card enable low marks every access to attribute, config or mailbox.
// - Register select low steers the access to attribute or I/O space.
// - Input acknowledge is low during an I/O read inside the I/O window.
// - In respond-all mode the acknowledge follows the I/O read strobe.
// - After reset the card is memory-only and busy until CPU sets ready.
// - Once configured the ready/busy line requests a host interrupt.
// - COR bit 6 picks a level interrupt or a pulse of at least 1 us.
// - Card reset high resets host access state, COR/CSR, mailbox flags, bus drive and ready/busy.
// - Card reset clears the configuration, leaving memory-only mode.
// - Firmware reloads attribute memory then sets ready to release busy.
// - Status change output follows a CPU control register bit.
// - Attribute writes need WE, CE, REG low and configured or ready.
// - Write data is committed when WE or CE rises to end the access.
// - Host I/O writes fill the mailbox, host I/O reads drain it.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"

module pcc_host_if #(
  parameter int AW        = 8,
  parameter int PULSE_CYC = `PCC_IRQ_PULSE_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire pcc_pkg::pcc_host_in_t host_i,
  input  wire logic                  card_reset_in_i,
  output var  pcc_pkg::pcc_host_out_t host_data_o,
  output var  logic                  io_read_ack_n_o,
  output var  logic                  ready_busy_irq_n_o,
  output var  logic                  status_change_out_o,
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output var  logic [15:0]           reg_rdata_o,
  output var  logic                  irq_o
);
  import pcc_pkg::*;

  // ==========================================
  // Pin synchronisers
  pcc_host_in_t h1_q, h_q, hp_q;
  logic         rst1_q, crst_q, crst_p_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      h1_q     <= '1;
      h_q      <= '1;
      hp_q     <= '1;
      rst1_q   <= 1'b1;
      crst_q   <= 1'b1;
      crst_p_q <= 1'b0;
    end else begin
      h1_q     <= host_i;
      h_q      <= h1_q;
      hp_q     <= h_q;
      rst1_q   <= card_reset_in_i;
      crst_q   <= rst1_q;
      crst_p_q <= crst_q;
    end
  end

  // ==========================================
  // Decode
  logic [7:0] ctrl_q, cor_q, csr_q, mbx_h2c_q, mbx_c2h_q, attr_addr_q;
  logic [9:0] io_base_q, io_mask_q;
  logic       h2c_full_q, c2h_full_q;
  logic       configured, ready, io_all, in_win, cfg_sel;
  logic       attr_rd, io_rd, attr_wr, io_wr;
  logic       io_rd_end, io_wr_end;

  assign configured = (cor_q[5:0] != 6'h00);
  assign ready      = ctrl_q[`PCC_CTRL_READY];
  assign io_all     = ctrl_q[`PCC_CTRL_IO_ALL];
  assign in_win     = ((h_q.addr ^ io_base_q) & ~io_mask_q) == 10'h000;
  assign cfg_sel    = h_q.addr[9];
  assign attr_rd = !h_q.oe_n && !h_q.ce_n && !h_q.reg_n;
  assign io_rd   = !h_q.iord_n && !h_q.ce_n && !h_q.reg_n
                   && configured && (in_win || io_all);
  assign io_wr   = !h_q.iowr_n && !h_q.ce_n && !h_q.reg_n
                   && configured && in_win;
  assign attr_wr = !h_q.we_n && !h_q.ce_n && !h_q.reg_n
                   && (configured || ready);

  // ==========================================
  // Access tracking, one action per host strobe
  logic       io_rd_q, io_wr_q, attr_wr_q, commit;
  logic [8:0] wr_addr_q;
  logic [7:0] wr_data_q;

  // commit when WE or CE ends the access
  assign commit    = attr_wr_q && (h_q.we_n || h_q.ce_n);
  assign io_rd_end = io_rd_q && h_q.iord_n && !hp_q.iord_n;
  assign io_wr_end = io_wr_q && h_q.iowr_n && !hp_q.iowr_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_rd_q   <= 1'b0;
      io_wr_q   <= 1'b0;
      attr_wr_q <= 1'b0;
      wr_addr_q <= 9'h000;
      wr_data_q <= 8'h00;
    end else if (crst_q) begin
      io_rd_q   <= 1'b0;
      io_wr_q   <= 1'b0;
      attr_wr_q <= 1'b0;
    end else begin
      io_rd_q   <= io_rd || (io_rd_q && !h_q.iord_n);
      io_wr_q   <= io_wr || (io_wr_q && !h_q.iowr_n);
      attr_wr_q <= attr_wr;
      if (attr_wr) begin
        wr_addr_q <= h_q.addr[9:1];
        wr_data_q <= h_q.data;
      end
    end
  end

  // ==========================================
  // Host configuration registers
  logic cfg_wr;
  assign cfg_wr = commit && wr_addr_q[8];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cor_q <= `PCC_COR_RST;
      csr_q <= 8'h00;
    end else if (crst_q) begin
      cor_q <= `PCC_COR_RST;
      csr_q <= 8'h00;
    end else if (cfg_wr) begin
      if (wr_addr_q == `PCC_CFG_COR) begin
        cor_q <= wr_data_q;
      end
      if (wr_addr_q == `PCC_CFG_CSR) begin
        csr_q <= wr_data_q;
      end
    end
  end

  // ==========================================
  // Attribute memory
  logic [7:0] ram_a_q, ram_b_q;
  logic       cpu_attr_we;

  assign cpu_attr_we = reg_we_i && reg_addr_i == `PCC_REG_ATTR_DATA;

  pcc_attr_ram #(
    .AW (AW),
    .DW (8)
  ) u_ram (
    .clk_i     (clk_i),
    .a_we_i    (commit && !wr_addr_q[8]),
    .a_addr_i  (commit ? wr_addr_q[AW-1:0] : h_q.addr[AW:1]),
    .a_wdata_i (wr_data_q),
    .a_rdata_o (ram_a_q),
    .b_we_i    (cpu_attr_we),
    .b_addr_i  (attr_addr_q[AW-1:0]),
    .b_wdata_i (reg_wdata_i[7:0]),
    .b_rdata_o (ram_b_q)
  );

  // ==========================================
  // Mailbox
  logic cpu_mbx_wr, cpu_mbx_rd;
  assign cpu_mbx_wr = reg_we_i && reg_addr_i == `PCC_REG_MBX;
  assign cpu_mbx_rd = reg_re_i && reg_addr_i == `PCC_REG_MBX;

  // host write fills, host read drains
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mbx_h2c_q  <= 8'h00;
      mbx_c2h_q  <= 8'h00;
      h2c_full_q <= 1'b0;
      c2h_full_q <= 1'b0;
    end else if (crst_q) begin
      h2c_full_q <= 1'b0;
      c2h_full_q <= 1'b0;
    end else begin
      if (io_wr && !io_wr_q) begin
        mbx_h2c_q <= h_q.data;
      end
      if (cpu_mbx_wr) begin
        mbx_c2h_q <= reg_wdata_i[7:0];
      end
      h2c_full_q <= io_wr_end || (h2c_full_q && !cpu_mbx_rd);
      c2h_full_q <= cpu_mbx_wr || (c2h_full_q && !io_rd_end);
    end
  end

  // ==========================================
  // Host data bus and input acknowledge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_data_o     <= '0;
      io_read_ack_n_o <= 1'b1;
    end else if (crst_q) begin
      host_data_o     <= '0;
      io_read_ack_n_o <= 1'b1;
    end else begin
      host_data_o.oe <= attr_rd || io_rd;
      if (io_rd) begin
        host_data_o.data <= mbx_c2h_q;
      end else if (!cfg_sel) begin
        host_data_o.data <= ram_a_q;
      end else if (h_q.addr[9:1] == `PCC_CFG_COR) begin
        host_data_o.data <= cor_q;
      end else if (h_q.addr[9:1] == `PCC_CFG_CSR) begin
        host_data_o.data <= csr_q | (8'(c2h_full_q) << `PCC_CSR_INTR);
      end else begin
        host_data_o.data <= 8'h00;
      end
      io_read_ack_n_o <= !io_rd;
    end
  end

  // ==========================================
  // Ready/busy and host interrupt
  pcc_irq_st_t irq_st_q;
  logic [7:0]  pulse_cnt_q;
  logic        c2h_prev_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_st_q    <= IRQ_IDLE;
      pulse_cnt_q <= 8'h00;
      c2h_prev_q  <= 1'b0;
    end else if (crst_q || !configured) begin
      irq_st_q    <= IRQ_IDLE;
      pulse_cnt_q <= 8'h00;
      c2h_prev_q  <= 1'b0;
    end else begin
      c2h_prev_q <= c2h_full_q;
      case (irq_st_q)
        IRQ_IDLE: begin
          if (c2h_full_q && !c2h_prev_q) begin
            irq_st_q    <= cor_q[`PCC_COR_LEVEL] ? IRQ_HOLD : IRQ_PULSE;
            pulse_cnt_q <= 8'(PULSE_CYC - 1);
          end
        end
        IRQ_PULSE: begin
          if (pulse_cnt_q == 8'h00) begin
            irq_st_q <= IRQ_IDLE;
          end else begin
            pulse_cnt_q <= pulse_cnt_q - 8'h01;
          end
        end
        IRQ_HOLD: begin
          if (!c2h_full_q) begin
            irq_st_q <= IRQ_IDLE;
          end
        end
        default: irq_st_q <= IRQ_IDLE;
      endcase
    end
  end

  // busy until ready, then interrupt line
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready_busy_irq_n_o <= 1'b0;
    end else if (crst_q) begin
      ready_busy_irq_n_o <= 1'b0;
    end else if (!configured) begin
      ready_busy_irq_n_o <= ready;
    end else begin
      ready_busy_irq_n_o <= (irq_st_q == IRQ_IDLE);
    end
  end

  // ==========================================
  // CPU-side registers
  logic [`PCC_EV_W-1:0] status_q, mask_q, ev;
  logic                 wr_ctrl;

  assign ev[`PCC_EV_CARD_RST] = crst_q && !crst_p_q;
  assign ev[`PCC_EV_HOST_WR]  = io_wr_end;
  assign ev[`PCC_EV_HOST_RD]  = io_rd_end;
  assign ev[`PCC_EV_CFG_WR]   = cfg_wr;
  assign wr_ctrl = reg_we_i && reg_addr_i == `PCC_REG_CTRL;

  // card reset drops ready, firmware sets it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `PCC_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {5'h00, reg_wdata_i[2:0]};
      end
      if (crst_q) begin
        ctrl_q[`PCC_CTRL_READY] <= 1'b0;
      end
    end
  end

  // Status set wins over write-one clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_q <= '0;
    end else if (reg_we_i && reg_addr_i == `PCC_REG_STATUS) begin
      status_q <= (status_q & ~reg_wdata_i[`PCC_EV_W-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_q      <= '0;
      io_base_q   <= 10'h000;
      io_mask_q   <= 10'h007;
      attr_addr_q <= 8'h00;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `PCC_REG_MASK:      mask_q      <= reg_wdata_i[`PCC_EV_W-1:0];
        `PCC_REG_IO_BASE:   io_base_q   <= reg_wdata_i[9:0];
        `PCC_REG_IO_MASK:   io_mask_q   <= reg_wdata_i[9:0];
        `PCC_REG_ATTR_ADDR: attr_addr_q <= reg_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `PCC_REG_CTRL:      reg_rdata_o <= {8'h00, ctrl_q};
        `PCC_REG_STATUS:    reg_rdata_o <= {12'h000, status_q};
        `PCC_REG_MASK:      reg_rdata_o <= {12'h000, mask_q};
        `PCC_REG_IO_BASE:   reg_rdata_o <= {6'h00, io_base_q};
        `PCC_REG_IO_MASK:   reg_rdata_o <= {6'h00, io_mask_q};
        `PCC_REG_MBX:
          reg_rdata_o <= {6'h00, c2h_full_q, h2c_full_q, mbx_h2c_q};
        `PCC_REG_COR:       reg_rdata_o <= {csr_q, cor_q};
        `PCC_REG_ATTR_ADDR: reg_rdata_o <= {8'h00, attr_addr_q};
        `PCC_REG_ATTR_DATA: reg_rdata_o <= {8'h00, ram_b_q};
        default:            reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // ==========================================
  // Outputs to firmware and host
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o               <= 1'b0;
      status_change_out_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
      status_change_out_o <= ctrl_q[`PCC_CTRL_STATUS_CHANGE_OUT];
    end
  end

endmodule

`default_nettype wire

// >>> test/pcc_host_if_sva.sv
// Checker of the card host interface ports
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"
module pcc_host_if_sva (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire pcc_pkg::pcc_host_in_t  host_i,
  input  wire logic                   card_reset_in_i,
  input  wire pcc_pkg::pcc_host_out_t host_data_o,
  input  wire logic                   io_read_ack_n_o,
  input  wire logic                   ready_busy_irq_n_o,
  input  wire logic                   status_change_out_o,
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [15:0]            reg_wdata_i,
  input  wire logic                   reg_we_i,
  input  wire logic                   reg_re_i,
  input  wire logic [15:0]            reg_rdata_o,
  input  wire logic                   irq_o
);
  import pcc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [4:0] rd_h_q;
  logic [4:0] io_h_q;
  // ==========================================
  // History of host read strobes at the pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_h_q <= 5'h00;
    end else begin
      rd_h_q <= {rd_h_q[3:0], !host_i.iord_n
                 || (!host_i.oe_n && !host_i.ce_n && !host_i.reg_n)};
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_h_q <= 5'h00;
    end else begin
      io_h_q <= {io_h_q[3:0], !host_i.iord_n};
    end
  end
  // ==========================================
  // Assertions
  a_status_change_out_follow: assert property (
    reg_we_i && reg_addr_i == `PCC_REG_CTRL
      |-> ##2 status_change_out_o == $past(reg_wdata_i[1], 2))
    else $error("status change output not following control bit");
  a_ack_has_read: assert property (
    !io_read_ack_n_o |-> io_h_q[4:1] != 4'h0)
    else $error("input acknowledge low without an I/O read");
  a_drive_has_read: assert property (
    host_data_o.oe |-> rd_h_q[4:1] != 4'h0)
    else $error("host data driven without a host read");
  a_busy_card_rst: assert property (
    card_reset_in_i [*5] |-> !ready_busy_irq_n_o && io_read_ack_n_o
      && !host_data_o.oe)
    else $error("card reset not holding the interface idle and busy");
  a_rdata_idle_zero: assert property (
    !reg_re_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    reg_re_i && reg_addr_i > `PCC_REG_ATTR_DATA |=> reg_rdata_o == 16'h0000)
    else $error("unmapped offset read not zero");
  a_irq_masked_off: assert property (
    reg_we_i && reg_addr_i == `PCC_REG_MASK && reg_wdata_i[3:0] == 4'h0
      ##1 !(reg_we_i && reg_addr_i == `PCC_REG_MASK) |=> !irq_o)
    else $error("interrupt high with all events masked");
  a_ctrl_width: assert property (
    reg_re_i && reg_addr_i == `PCC_REG_CTRL |=> reg_rdata_o[15:3] == 13'h0)
    else $error("control register upper bits not zero");
  c_ack_low: cover property (!io_read_ack_n_o);
  c_line_fell: cover property ($fell(ready_busy_irq_n_o));
  c_irq_high: cover property (irq_o);
endmodule
bind pcc_host_if pcc_host_if_sva i_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .host_i(host_i),
  .card_reset_in_i(card_reset_in_i), .host_data_o(host_data_o),
  .io_read_ack_n_o(io_read_ack_n_o),
  .ready_busy_irq_n_o(ready_busy_irq_n_o),
  .status_change_out_o(status_change_out_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
`default_nettype wire

// >>> test/pcc_host_model.sv
// Host socket adapter model that drives the card pins
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
  input  wire logic                   clk_i,
  input  wire pcc_pkg::pcc_host_out_t host_data_i,
  input  wire logic                   ack_n_i,
  output var  pcc_pkg::pcc_host_in_t  host_o,
  output var  logic                   card_reset_o
);
  import pcc_pkg::*;
  initial begin
    host_o = '1;
    card_reset_o = 1'b0;
  end
  // ==========================================
  // Kinds: 0 attr write, 1 attr read, 2 I/O write, 3 I/O read
  // strobe low inside card enable
  task automatic acc(input logic [1:0] k, input logic [9:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic ak);
    ak = 1'b0;
    @(posedge clk_i);
    host_o.addr  <= a;
    host_o.data  <= k[0] ? ~host_o.data : d;
    host_o.ce_n  <= 1'b0;
    host_o.reg_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    // Bit order oe, we, iord, iowr
    {host_o.oe_n, host_o.we_n, host_o.iord_n, host_o.iowr_n}
      <= ~(4'h1 << {~k[1], k[0]});
    repeat (10) begin
      @(posedge clk_i);
      ak |= !ack_n_i;
      q = host_data_i.data;
    end
    {host_o.oe_n, host_o.we_n, host_o.iord_n, host_o.iowr_n} <= 4'hF;
    repeat (3) @(posedge clk_i);
    host_o.ce_n  <= 1'b1;
    host_o.reg_n <= 1'b1;
    host_o.data  <= ~host_o.data;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic pulse_reset();
    @(posedge clk_i);
    card_reset_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    card_reset_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> test/pc_card_host_interface_tb.sv
// Bench of the card host interface with a host socket model
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"
module pc_card_host_interface_tb;
  import pcc_pkg::*;
  logic          clk_i = 1'b0;
  logic          resetn_i = 1'b0;
  pcc_host_in_t  host;
  pcc_host_out_t hout;
  logic          crst, ack_n, rb_n, status_change_out, irq, ak;
  logic          re_q = 1'b0;
  logic [3:0]    r_a = 4'h0;
  logic [15:0]   r_wd = 16'h0000;
  logic          r_we = 1'b0;
  logic          r_re = 1'b0;
  logic [15:0]   r_rd;
  logic [15:0]   exp_q[$];
  logic [7:0]    d, q;
  int            mismatches = 0;
  int            total_checks = 0;
  int            cyc = 0;
  int            n;
  int            seed = 32'h0363BC47;
  pcc_host_if i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .host_i(host),
    .card_reset_in_i(crst), .host_data_o(hout),
    .io_read_ack_n_o(ack_n), .ready_busy_irq_n_o(rb_n),
    .status_change_out_o(status_change_out), .reg_addr_i(r_a),
    .reg_wdata_i(r_wd), .reg_we_i(r_we), .reg_re_i(r_re),
    .reg_rdata_o(r_rd), .irq_o(irq));
  pcc_host_model i_host (
    .clk_i(clk_i), .host_data_i(hout), .ack_n_i(ack_n),
    .host_o(host), .card_reset_o(crst));
  always #25 clk_i = ~clk_i;
  // ==========================================
  // Tasks
  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    r_a <= a;
    r_wd <= v;
    r_we <= 1'b1;
    @(posedge clk_i);
    r_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] v);
    exp_q.push_back(v);
    @(posedge clk_i);
    r_a <= a;
    r_re <= 1'b1;
    @(posedge clk_i);
    r_re <= 1'b0;
  endtask
  function automatic logic pin(input int s);
    return s == 0 ? rb_n : s == 1 ? irq : status_change_out;
  endfunction
  // Waits a bounded time for a level on an output, then compares
  task automatic see(input int s, input logic v);
    string nm;
    nm = "status_change_out";
    if (s == 0) nm = "ready_busy";
    if (s == 1) nm = "irq";
    for (n = 0; n < 60 && pin(s) !== v; n++) begin
      @(posedge clk_i);
      #1;
    end
    check(nm, pin(s), v);
  endtask
  // ==========================================
  // Read result monitor and timeout
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    re_q <= r_re;
    if (re_q) check("rdata", r_rd, exp_q.pop_front());
    if (cyc == 6000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    see(0, 1'b0);
    rd(`PCC_REG_CTRL, 16'h0000);
    rd(`PCC_REG_STATUS, 16'h0001);
    rd(`PCC_REG_MASK, 16'h0000);
    rd(`PCC_REG_IO_MASK, 16'h0007);
    rd(`PCC_REG_COR, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(`PCC_REG_STATUS, 16'h000F);
    rd(`PCC_REG_STATUS, 16'h0000);
    wr(`PCC_REG_ATTR_ADDR, 16'h0002);
    wr(`PCC_REG_ATTR_DATA, 16'h003C);
    i_host.acc(2'd0, 10'h004, 8'hA5, q, ak);
    rd(`PCC_REG_ATTR_DATA, 16'h003C);
    wr(`PCC_REG_CTRL, 16'hFFF9);
    rd(`PCC_REG_CTRL, 16'h0001);
    see(0, 1'b1);
    d = 8'($random(seed));
    i_host.acc(2'd0, 10'h004, d, q, ak);
    rd(`PCC_REG_ATTR_DATA, {8'h00, d});
    d = 8'($random(seed));
    wr(`PCC_REG_ATTR_ADDR, 16'h0005);
    wr(`PCC_REG_ATTR_DATA, {8'h00, d});
    i_host.acc(2'd1, 10'h00A, 8'h00, q, ak);
    check("attr_read", q, d);
    i_host.acc(2'd3, 10'h101, 8'h00, q, ak);
    check("ack_unconfigured", ak, 1'b0);
    i_host.acc(2'd0, 10'h200, 8'h41, q, ak);
    rd(`PCC_REG_COR, 16'h0041);
    i_host.acc(2'd1, 10'h200, 8'h00, q, ak);
    check("cor_read", q, 8'h41);
    wr(`PCC_REG_IO_BASE, 16'h0100);
    d = 8'($random(seed));
    i_host.acc(2'd2, 10'h103, d, q, ak);
    rd(`PCC_REG_MBX, {8'h01, d});
    d = 8'($random(seed));
    wr(`PCC_REG_MBX, {8'h00, d});
    see(0, 1'b0);
    repeat (40) @(posedge clk_i);
    see(0, 1'b0);
    i_host.acc(2'd1, 10'h202, 8'h00, q, ak);
    check("csr_pending", q, 8'h02);
    i_host.acc(2'd3, 10'h101, 8'h00, q, ak);
    check("mailbox_read", q, d);
    check("ack_inside", ak, 1'b1);
    see(0, 1'b1);
    i_host.acc(2'd3, 10'h180, 8'h00, q, ak);
    check("ack_outside", ak, 1'b0);
    wr(`PCC_REG_CTRL, 16'h0005);
    i_host.acc(2'd3, 10'h180, 8'h00, q, ak);
    check("ack_all", ak, 1'b1);
    i_host.acc(2'd0, 10'h200, 8'h01, q, ak);
    wr(`PCC_REG_MBX, {8'h00, 8'h55});
    see(0, 1'b0);
    for (n = 0; n < 80 && rb_n !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    check("pulse", n >= `PCC_IRQ_PULSE_CYC && n < 80, 1'b1);
    wr(`PCC_REG_MASK, 16'h0002);
    see(1, 1'b1);
    wr(`PCC_REG_STATUS, 16'h0002);
    see(1, 1'b0);
    i_host.acc(2'd2, 10'h104, 8'h00, q, ak);
    see(1, 1'b1);
    wr(`PCC_REG_MASK, 16'h0000);
    see(1, 1'b0);
    wr(`PCC_REG_CTRL, 16'h0007);
    see(2, 1'b1);
    wr(`PCC_REG_CTRL, 16'h0005);
    see(2, 1'b0);
    wr(`PCC_REG_STATUS, 16'h000F);
    i_host.pulse_reset();
    see(0, 1'b0);
    rd(`PCC_REG_COR, 16'h0000);
    rd(`PCC_REG_STATUS, 16'h0001);
    wr(`PCC_REG_CTRL, 16'h0001);
    see(0, 1'b1);
    i_host.acc(2'd3, 10'h101, 8'h00, q, ak);
    check("ack_after_reset", ak, 1'b0);
    repeat (5) @(posedge clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
